// [hw/pch_pkg.sv]
// Contract
// R1 - Each controller takes eight request inputs and arbitrates them by priority.
// R2 - Each request input can be masked out of priority resolution.
// R3 - During acknowledge the controller returns the programmed vector of the top request.
// R4 - Host adds one wait state to every register read or write cycle.
// R5 - Host leaves at least 500 ns between accesses, acknowledge sequences included.
// R6 - Host runs two consecutive acknowledge cycles for each accepted interrupt.
// R7 - Host stretches each acknowledge cycle by at least one wait state.
// R8 - Host inserts three idle bus states between the two acknowledge cycles.
// R9 - A slave resolves eight inputs and sends one request to the master.
// R10 - The master resolves eight slaves into one processor request, 64 total.
// R11 - All controllers freeze their request inputs in the first acknowledge cycle.
// R12 - Master drives cascade address; host gates, latches it onto A8-A10.
// R13 - The cascade address names the slave holding the top pending request.
// R14 - Only the addressed slave drives its vector in the second acknowledge cycle.
// R15 - A third-level controller raises one slave input, which propagates upward.
// R16 - To poll, host writes the poll command then immediately reads that controller.
// R17 - Service code polls third-level controllers to find the real source.
// R18 - Keep the third level for less critical, infrequent sources.
// R19 - Host decode gives each polled controller its own chip select.
package pch_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BUS_STATE_NS = 80;
	localparam int WAIT_STATES = 1;
	localparam int ACK_WAIT_STATES = 1;
	localparam int ACK_IDLE_STATES = 3;
	localparam int RD_PULSE_NS = 160;
	localparam int WR_PULSE_NS = 190;
	localparam int ACK_PULSE_NS = 160;
	localparam int ACK_GAP_NS = 160;
	localparam int ACCESS_SPACE_NS = 500;
	localparam int CNT_W = 8;
	localparam int SEL_W = 3;
	localparam int DATA_W = 8;
	localparam int CAS_W = 3;

	function automatic int pch_ceil_cyc(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : pch_ceil_cyc

	function automatic int pch_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : pch_max

	localparam int STATE_CYC = pch_ceil_cyc(BUS_STATE_NS);
	localparam int RD_CYC = pch_max(pch_ceil_cyc(RD_PULSE_NS), (1 + WAIT_STATES) * STATE_CYC);
	localparam int WR_CYC = pch_max(pch_ceil_cyc(WR_PULSE_NS), (1 + WAIT_STATES) * STATE_CYC);
	localparam int ACK_CYC = pch_max(pch_ceil_cyc(ACK_PULSE_NS),
		(1 + ACK_WAIT_STATES) * STATE_CYC);
	localparam int GAP_CYC = pch_max(pch_ceil_cyc(ACK_GAP_NS), ACK_IDLE_STATES * STATE_CYC);
	localparam int SPACE_CYC = pch_ceil_cyc(ACCESS_SPACE_NS);

	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
	localparam logic [CNT_W-1:0] ACK_LOAD = CNT_W'(ACK_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] SPACE_LOAD = CNT_W'(SPACE_CYC);

	typedef enum logic [1:0] {
		PCH_READ = 2'h0,
		PCH_WRITE = 2'h1,
		PCH_POLL = 2'h2
	} pch_kind_t;

	typedef struct packed {
		pch_kind_t kind;
		logic [SEL_W-1:0] sel;
		logic a0;
		logic [DATA_W-1:0] data;
	} pch_req_t;

	typedef struct packed {
		logic [CAS_W-1:0] cas;
		logic [DATA_W-1:0] vector;
	} pch_vec_t;
endpackage : pch_pkg

// [hw/pch_spacer.sv]
`timescale 1ns/1ps
module pch_spacer
	import pch_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	output logic busy_out
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (start_in) begin
			cnt_next = SPACE_LOAD; // [R5]
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Start is only raised outside idle, so leaving it out keeps ready free of a loop
	assign busy_out = (cnt_reg != '0);
endmodule : pch_spacer

// [hw/pch_host.sv]
`timescale 1ns/1ps
module pch_host
	import pch_pkg::*;
#(
	parameter int NUM_CS = 8
)
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic req_valid_in,
	input wire pch_req_t req_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [DATA_W-1:0] rsp_data_out,
	input wire logic ack_enable_in,
	output logic vec_valid_out,
	output pch_vec_t vec_out,
	output logic ack_busy_out,
	input wire logic pic_intr_in,
	input wire logic [CAS_W-1:0] pic_cas_in,
	input wire logic [DATA_W-1:0] pic_data_in,
	output logic [DATA_W-1:0] pic_data_out,
	output logic pic_data_oe_out,
	output logic [NUM_CS-1:0] pic_cs_n_out,
	output logic pic_a0_out,
	output logic pic_rd_n_out,
	output logic pic_wr_n_out,
	output logic irq_ack_strobe_n_out,
	output logic cascade_addr_enable_out,
	output logic addr_strobe_out,
	output logic [CAS_W-1:0] cas_addr_out
);
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_SETUP = 8'h02,
		S_STROBE = 8'h04,
		S_HOLD = 8'h08,
		S_POLL_GAP = 8'h10,
		S_ACK1 = 8'h20,
		S_ACK_GAP = 8'h40,
		S_ACK2 = 8'h80
	} pch_state_t;

	pch_state_t state_reg, state_next;
	pch_req_t cur_reg, cur_next;
	logic phase_reg, phase_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [DATA_W-1:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic [NUM_CS-1:0] cs_n_reg, cs_n_next;
	logic a0_reg, a0_next;
	logic rd_n_reg, rd_n_next;
	logic wr_n_reg, wr_n_next;
	logic ack_n_reg, ack_n_next;
	logic cae_reg, cae_next;
	logic as_reg, as_next;
	logic [CAS_W-1:0] cas_reg, cas_next;
	logic rsp_v_reg, rsp_v_next;
	logic [DATA_W-1:0] rsp_d_reg, rsp_d_next;
	logic vec_v_reg, vec_v_next;
	pch_vec_t vec_reg, vec_next;

	logic intr_s1_reg, intr_s2_reg;
	logic [CAS_W-1:0] cas_s1_reg, cas_s2_reg;
	logic [DATA_W-1:0] din_s1_reg, din_s2_reg;

	logic space_busy;
	logic space_start;
	logic ack_go;

	function automatic logic is_read(input pch_req_t r, input logic ph);
		return (r.kind == PCH_READ) || ((r.kind == PCH_POLL) && ph);
	endfunction : is_read

	function automatic logic [NUM_CS-1:0] sel_onehot_n(input logic [SEL_W-1:0] s);
		logic [NUM_CS-1:0] v;
		v = '1;
		if (int'(s) < NUM_CS) begin
			v[s] = 1'b0;
		end
		return v;
	endfunction : sel_onehot_n

	pch_spacer u_spacer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(space_start),
		.busy_out(space_busy)
	);

	// Pins from the controllers are asynchronous to this clock
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			intr_s1_reg <= 1'b0;
			intr_s2_reg <= 1'b0;
			cas_s1_reg <= '0;
			cas_s2_reg <= '0;
			din_s1_reg <= '0;
			din_s2_reg <= '0;
		end else begin
			intr_s1_reg <= pic_intr_in;
			intr_s2_reg <= intr_s1_reg;
			cas_s1_reg <= pic_cas_in;
			cas_s2_reg <= cas_s1_reg;
			din_s1_reg <= pic_data_in;
			din_s2_reg <= din_s1_reg;
		end
	end

	// Acknowledge takes precedence over commands; spacing still applies to it
	assign ack_go = intr_s2_reg && ack_enable_in && !space_busy; // [R5] [R6]
	assign req_ready_out = (state_reg == S_IDLE) && !space_busy && !ack_go; // [R5]

	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		phase_next = phase_reg;
		cnt_next = cnt_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		cs_n_next = cs_n_reg;
		a0_next = a0_reg;
		rd_n_next = rd_n_reg;
		wr_n_next = wr_n_reg;
		ack_n_next = ack_n_reg;
		cae_next = cae_reg;
		as_next = 1'b0;
		cas_next = cas_reg;
		rsp_v_next = 1'b0;
		rsp_d_next = rsp_d_reg;
		vec_v_next = 1'b0;
		vec_next = vec_reg;
		space_start = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (ack_go) begin
					ack_n_next = 1'b0;
					cae_next = 1'b1; // [R12]
					cnt_next = ACK_LOAD; // [R7]
					state_next = S_ACK1;
				end else if (req_valid_in && req_ready_out) begin
					cur_next = req_in;
					phase_next = 1'b0;
					cs_n_next = sel_onehot_n(req_in.sel); // [R19]
					a0_next = req_in.a0;
					dout_next = req_in.data;
					oe_next = (req_in.kind != PCH_READ);
					state_next = S_SETUP;
				end
			end
			// Address and select lead the strobe by one cycle; no command delay
			S_SETUP: begin
				if (is_read(cur_reg, phase_reg)) begin
					rd_n_next = 1'b0;
					cnt_next = RD_LOAD; // [R4]
				end else begin
					wr_n_next = 1'b0;
					cnt_next = WR_LOAD; // [R4]
				end
				state_next = S_STROBE;
			end
			S_STROBE: begin
				if (cnt_reg == '0) begin
					rd_n_next = 1'b1;
					wr_n_next = 1'b1;
					if (is_read(cur_reg, phase_reg)) begin
						rsp_d_next = din_s2_reg;
					end
					state_next = S_HOLD;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			S_HOLD: begin
				cs_n_next = '1;
				oe_next = 1'b0;
				space_start = 1'b1; // [R5]
				if ((cur_reg.kind == PCH_POLL) && !phase_reg) begin
					phase_next = 1'b1;
					state_next = S_POLL_GAP;
				end else begin
					rsp_v_next = 1'b1;
					state_next = S_IDLE;
				end
			end
			// Nothing else may reach the bus between the poll write and its read
			S_POLL_GAP: begin
				if (!space_busy) begin
					cs_n_next = sel_onehot_n(cur_reg.sel); // [R16] [R17]
					state_next = S_SETUP;
				end
			end
			S_ACK1: begin
				if (cnt_reg == '0) begin
					ack_n_next = 1'b1;
					as_next = 1'b1;
					cas_next = cas_s2_reg; // [R12]
					cnt_next = GAP_LOAD; // [R8]
					state_next = S_ACK_GAP;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			S_ACK_GAP: begin
				if (cnt_reg == '0) begin
					ack_n_next = 1'b0;
					cnt_next = ACK_LOAD; // [R7]
					state_next = S_ACK2;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			S_ACK2: begin
				if (cnt_reg == '0) begin
					ack_n_next = 1'b1;
					cae_next = 1'b0;
					vec_next.vector = din_s2_reg; // [R14]
					vec_next.cas = cas_reg;
					vec_v_next = 1'b1;
					space_start = 1'b1; // [R5]
					state_next = S_IDLE;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= S_IDLE;
			cur_reg <= '0;
			phase_reg <= 1'b0;
			cnt_reg <= '0;
			dout_reg <= '0;
			oe_reg <= 1'b0;
			cs_n_reg <= '1;
			a0_reg <= 1'b0;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			ack_n_reg <= 1'b1;
			cae_reg <= 1'b0;
			as_reg <= 1'b0;
			cas_reg <= '0;
			rsp_v_reg <= 1'b0;
			rsp_d_reg <= '0;
			vec_v_reg <= 1'b0;
			vec_reg <= '0;
		end else begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			phase_reg <= phase_next;
			cnt_reg <= cnt_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			cs_n_reg <= cs_n_next;
			a0_reg <= a0_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			ack_n_reg <= ack_n_next;
			cae_reg <= cae_next;
			as_reg <= as_next;
			cas_reg <= cas_next;
			rsp_v_reg <= rsp_v_next;
			rsp_d_reg <= rsp_d_next;
			vec_v_reg <= vec_v_next;
			vec_reg <= vec_next;
		end
	end

	assign rsp_valid_out = rsp_v_reg;
	assign rsp_data_out = rsp_d_reg;
	assign vec_valid_out = vec_v_reg;
	assign vec_out = vec_reg;
	assign ack_busy_out = (state_reg == S_ACK1) || (state_reg == S_ACK_GAP) ||
		(state_reg == S_ACK2);
	assign pic_data_out = dout_reg;
	assign pic_data_oe_out = oe_reg;
	assign pic_cs_n_out = cs_n_reg;
	assign pic_a0_out = a0_reg;
	assign pic_rd_n_out = rd_n_reg;
	assign pic_wr_n_out = wr_n_reg;
	assign irq_ack_strobe_n_out = ack_n_reg;
	assign cascade_addr_enable_out = cae_reg;
	assign addr_strobe_out = as_reg;
	// Latched cascade address held until the next acknowledge replaces it
	assign cas_addr_out = cas_reg; // [R12]
endmodule : pch_host

// [verification/pch_host_properties.sv]
`timescale 1ns/1ps
module pch_host_props
	import pch_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic pic_rd_n_out,
	input wire logic pic_wr_n_out,
	input wire logic irq_ack_strobe_n_out,
	input wire logic cascade_addr_enable_out,
	input wire logic addr_strobe_out,
	input wire logic vec_valid_out
);
	logic [2:0] stb;
	logic [7:0] lo_reg [3];
	logic [7:0] lo_next [3];
	logic [7:0] idle_reg, idle_next;
	logic quiet;
	assign stb = {irq_ack_strobe_n_out, pic_wr_n_out, pic_rd_n_out};
	assign quiet = &stb;
	always_comb begin
		for (int i = 0; i < 3; i++)
			lo_next[i] = stb[i] ? 8'h00 : lo_reg[i] + 8'h01;
		idle_next = !(&stb) ? 8'h00 : idle_reg + 8'(idle_reg != 8'hFF);
	end
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lo_reg <= '{default: 8'h00};
			idle_reg <= 8'hFF; // Reset counts as a long quiet spell
		end else begin
			lo_reg <= lo_next;
			idle_reg <= idle_next;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_rd_width: assert property ($rose(pic_rd_n_out) |-> lo_reg[0] >= RD_CYC)
		else $error("read strobe short");
	a_wr_width: assert property ($rose(pic_wr_n_out) |-> lo_reg[1] >= WR_CYC)
		else $error("write strobe short");
	a_ack_width: assert property ($rose(irq_ack_strobe_n_out) |-> lo_reg[2] >= ACK_CYC)
		else $error("ack strobe short");
	a_ack_gap: assert property ($fell(irq_ack_strobe_n_out) && $past(cascade_addr_enable_out)
		|-> idle_reg >= GAP_CYC) else $error("ack gap short");
	a_access_space: assert property (!$past(cascade_addr_enable_out) && !quiet
		&& $past(quiet) |-> idle_reg >= SPACE_CYC) else $error("accesses too close");
	a_ack_pair: assert property ($rose(cascade_addr_enable_out) |-> ##[30:90]
		($fell(irq_ack_strobe_n_out) && cascade_addr_enable_out)) else $error("no second ack");
	a_cas_latch: assert property (addr_strobe_out |-> cascade_addr_enable_out
		&& irq_ack_strobe_n_out) else $error("cascade latch misplaced");
	a_vec_done: assert property ($fell(cascade_addr_enable_out) |-> ##[0:2] vec_valid_out)
		else $error("vector not reported");
endmodule : pch_host_props
bind pch_host pch_host_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.pic_rd_n_out(pic_rd_n_out), .pic_wr_n_out(pic_wr_n_out),
	.irq_ack_strobe_n_out(irq_ack_strobe_n_out), .cascade_addr_enable_out(cascade_addr_enable_out),
	.addr_strobe_out(addr_strobe_out), .vec_valid_out(vec_valid_out));

// [verification/pch_pic_model.sv]
`timescale 1ns/1ps
module pch_pic_model
	import pch_pkg::*;
(
	input wire logic [7:0] irq_in,
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic a0_in,
	input wire logic ack_n_in,
	input wire logic [DATA_W-1:0] data_in,
	output logic intr_out,
	output logic [CAS_W-1:0] cas_out = 3'h0,
	output logic [DATA_W-1:0] data_out = 8'h00
);
	logic [7:0] mask_reg = 8'h00, vec_reg = 8'h00, frz_reg = 8'h00, live;
	logic poll_reg = 1'b0, second_reg = 1'b0, low_seen = 1'b0;
	function automatic logic [2:0] top(input logic [7:0] v);
		top = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (v[i]) top = 3'(i);
	endfunction : top
	assign live = irq_in & ~mask_reg;
	assign intr_out = |live;
	always @(posedge wr_n_in) begin
		if (!cs_n_in && a0_in) mask_reg = data_in;
		if (!cs_n_in && !a0_in) poll_reg = data_in[2]; // Bit 2 marks a poll command
		if (!cs_n_in && !a0_in && !data_in[2]) vec_reg = data_in;
	end
	always @(posedge rd_n_in) if (!cs_n_in) poll_reg = 1'b0;
	always @(negedge ack_n_in) begin
		low_seen = 1'b1;
		if (!second_reg) frz_reg = live;
		cas_out = top(frz_reg);
	end
	// The rise out of the unknown power-up level is not the end of a cycle
	always @(posedge ack_n_in) begin
		if (low_seen) second_reg = !second_reg;
		low_seen = 1'b0;
	end
	// Released bus inverts its last value at each input change, so a second change restores it
	always @(cs_n_in, rd_n_in, ack_n_in, second_reg, live, poll_reg) begin
		if (!cs_n_in && !rd_n_in) data_out = poll_reg ? {5'h10, top(live)} : mask_reg;
		else if (!ack_n_in && second_reg) data_out = vec_reg + 8'(top(frz_reg));
		else data_out = ~data_out;
	end
endmodule : pch_pic_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb
	import pch_pkg::*;
;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0, ack_enable_in = 1'b0;
	pch_req_t req_in = '0;
	logic [7:0] irq = 8'h00, last = 8'h00, mask, vbase, v;
	logic req_ready_out, rsp_valid_out, vec_valid_out, ack_busy_out, intr, oe, rd_n, wr_n, ack_n, a0;
	logic [7:0] rsp_data_out, pd_out, m_data, bus, cs_n;
	logic [2:0] cas, cas_addr_out, c;
	pch_vec_t vec_out;
	int err_total = 0, comparisons = 0, seed = 43;
	logic [7:0] rsp_q [$];
	pch_vec_t vec_q [$];
	assign bus = oe ? pd_out : m_data;
	always #5 clk_in = ~clk_in;
	pch_host u_pch_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_data_out(rsp_data_out), .ack_enable_in(ack_enable_in), .vec_valid_out(vec_valid_out),
		.vec_out(vec_out), .ack_busy_out(ack_busy_out), .pic_intr_in(intr), .pic_cas_in(cas),
		.pic_data_in(bus), .pic_data_out(pd_out), .pic_data_oe_out(oe), .pic_cs_n_out(cs_n),
		.pic_a0_out(a0), .pic_rd_n_out(rd_n), .pic_wr_n_out(wr_n), .irq_ack_strobe_n_out(ack_n),
		.cascade_addr_enable_out(), .addr_strobe_out(), .cas_addr_out(cas_addr_out));
	pch_pic_model u_pch_pic_model (.irq_in(irq), .cs_n_in(cs_n[0]), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .a0_in(a0), .ack_n_in(ack_n), .data_in(bus), .intr_out(intr),
		.cas_out(cas), .data_out(m_data));
	function automatic logic [2:0] first_set(input logic [7:0] x);
		first_set = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (x[i]) first_set = 3'(i);
	endfunction : first_set
	task automatic judge(input logic [10:0] got, input logic [10:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : judge
	task automatic cmp_rsp(input logic [7:0] got);
		judge({3'h0, got}, {3'h0, rsp_q.pop_front()});
	endtask : cmp_rsp
	task automatic cmp_vec(input pch_vec_t got, input logic [2:0] lat);
		pch_vec_t e;
		e = vec_q.pop_front();
		judge(got, e);
		judge({lat, 8'h00}, {e.cas, 8'h00});
	endtask : cmp_vec
	task automatic results();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	// Writes leave the read register alone, so they expect the last read value
	task automatic access(input pch_kind_t k, input logic [2:0] s, input logic a,
		input logic [7:0] d, input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk_in);
		if (k != PCH_WRITE) last = e;
		rsp_q.push_back(last);
		req_valid_in <= 1'b1;
		req_in <= '{kind: k, sel: s, a0: a, data: d};
		do begin
			@(negedge clk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 400);
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		if (n >= 400) err_total++;
	endtask : access
	task automatic wait_hi(input bit vec);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while ((vec ? vec_valid_out : ack_busy_out) !== 1'b1 && n < 400);
		repeat (2) @(posedge clk_in);
		if (n >= 400) err_total++;
	endtask : wait_hi
	always @(posedge clk_in) begin
		if (rsp_valid_out === 1'b1) cmp_rsp(rsp_data_out);
		if (vec_valid_out === 1'b1) cmp_vec(vec_out, cas_addr_out);
	end
	initial begin
		mask = 8'($random(seed)) & 8'h7F;
		vbase = 8'($random(seed)) & 8'hF8;
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		access(PCH_WRITE, 3'h0, 1'b1, mask, 8'h00);
		access(PCH_WRITE, 3'h0, 1'b0, vbase, 8'h00);
		access(PCH_WRITE, 3'h5, 1'b1, 8'hFF, 8'h00);
		access(PCH_READ, 3'h0, 1'b1, 8'h00, mask);
		irq <= ~mask;
		access(PCH_POLL, 3'h0, 1'b0, 8'h04, {5'h10, first_set(~mask)});
		// Poll read phase must finish before the request pattern moves on
		repeat (120) @(posedge clk_in);
		ack_enable_in <= 1'b1;
		for (int r = 0; r < 5; r++) begin
			v = 8'($random(seed)) | 8'h80;
			c = first_set(v & ~mask);
			vec_q.push_back('{cas: c, vector: vbase + 8'(c)});
			irq <= v;
			wait_hi(1'b0);
			irq <= 8'hFF;
			wait_hi(1'b1);
		end
		ack_enable_in <= 1'b0;
		irq <= 8'h00;
		repeat (100) @(posedge clk_in);
		results();
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule : tb
